/* File: src/footswitch_midi_event_gen.sv */
// Rear jack switch and pedal sensing, MIDI event generation and part response
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "fsw_consts.svh"

module footswitch_midi_event_gen
    import fsw_pkg::*;
#(
    parameter int NPARTS = 8,
    parameter int DEBOUNCE_CYC = `DEBOUNCE_US * `CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] jack_i,
    input wire logic [6:0] pedal_ring_i,
    input wire logic [6:0] pedal_tip_i,
    input wire logic rx_valid_i,
    input wire logic [1:0] rx_kind_i,
    input wire logic [3:0] rx_chan_i,
    input wire logic [6:0] rx_value_i,
    output logic msg_valid_o,
    input wire logic msg_ready_i,
    output logic msg_nrpn_o,
    output logic [6:0] msg_num_msb_o,
    output logic [6:0] msg_num_lsb_o,
    output logic [6:0] msg_value_o,
    output logic [3:0] msg_chan_o,
    output logic arp_mute_o,
    output logic sustain_o,
    output logic arp_latch_o,
    output logic voc_freeze_o,
    output logic audio1_avail_o,
    output logic audio2_avail_o,
    output logic [NPARTS-1:0] part_sustain_o,
    output logic [NPARTS-1:0] part_latch_o,
    output logic [NPARTS-1:0] part_mute_o
);
    localparam int DW = $clog2(DEBOUNCE_CYC + 1);
    localparam int PW = (NPARTS > 1) ? $clog2(NPARTS) : 1;
    localparam int SW = 17;
    localparam int MW = 26;
    localparam logic [DW-1:0] DEB_LAST = DW'(DEBOUNCE_CYC - 1);
    localparam logic [PW-1:0] PART_LAST = PW'(NPARTS - 1);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Merge a write under byte enables
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (o & ~m) | (n & m);
    endfunction

    // Apply one switch event to a part's state {mute, latch, sustain}
    function automatic logic [2:0] apply(input logic [2:0] st, input resp_t rs,
                                         input logic on);
        logic [2:0] r;
        r = st;
        unique case (rs)
            `RESP_SUS: r[0] = on;
            `RESP_SUS_I: r[0] = ~on;
            `RESP_LAT: r[1] = on;
            `RESP_LAT_I: r[1] = ~on;
            `RESP_MUTE: r[2] = on;
            `RESP_MUTE_I: r[2] = ~on;
            default: r = st;
        endcase
        return r;
    endfunction

    // Control registers
    logic [11:0] ctrl_r;
    logic [3*NPARTS-1:0] txen_r;
    logic [4*NPARTS-1:0] chan_r;
    logic [3*NPARTS-1:0] rsus_r;
    logic [3*NPARTS-1:0] rsw1_r;
    logic [3*NPARTS-1:0] rsw3_r;
    logic ack_r;
    logic [31:0] dat_r;

    // Mode decode of the control word
    wire [1:0] j1_mode = ctrl_r[`CTRL_J1_LSB +: 2];
    wire [1:0] j2_mode = ctrl_r[`CTRL_J2_LSB +: 2];
    wire [1:0] j3_mode = ctrl_r[`CTRL_J3_LSB +: 2];
    wire perf = ctrl_r[`CTRL_PERF];
    wire arp_on = ctrl_r[`CTRL_ARP];
    wire [3:0] gchan = ctrl_r[`CTRL_CH_LSB +: 4];
    // Codes 3 on jacks one and two fall back to audio
    wire [2:0] sw_en = {j3_mode[1],
                        j2_mode == `MODE_SW || j2_mode == `MODE_SWI,
                        j1_mode == `MODE_SW || j1_mode == `MODE_SWI};
    wire [2:0] sw_inv = {j3_mode == `MODE3_SWI, j2_mode == `MODE_SWI,
                         j1_mode == `MODE_SWI};
    wire ped_en = ~j3_mode[1];

    // Bus address decode
    wire [7:0] adr_w = {wb_adr_i[7:2], 2'b00};
    wire req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wr = req & wb_we_i;
    wire sel_ctrl = adr_w == `OFF_CTRL;
    wire sel_txen = adr_w == `OFF_TXEN;
    wire sel_chan = adr_w == `OFF_CHAN;
    wire sel_rsus = adr_w == `OFF_RSUS;
    wire sel_rsw1 = adr_w == `OFF_RSW1;
    wire sel_rsw3 = adr_w == `OFF_RSW3;
    wire sel_stat = adr_w == `OFF_STAT;

    // Pin synchronisers: three stages, a change counts once stages two and three agree
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic [SW-1:0] s3_r;
    logic [SW-1:0] filt_r;
    wire [SW-1:0] pins = {pedal_tip_i, pedal_ring_i, jack_i};
    always_ff @(posedge clk_i) begin
        s1_r <= pins;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_filt
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    filt_r[gi] <= 1'b0;
                end else if (s2_r[gi] == s3_r[gi]) begin
                    filt_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate

    // Debounce each switch; a closed contact reads high, inverted switches rest closed
    logic [2:0] stable_r;
    logic [2:0] chg;
    wire [2:0] sensed = filt_r[2:0] ^ sw_inv;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_deb
            logic [DW-1:0] cnt_r;
            assign chg[gi] = (sensed[gi] != stable_r[gi]) && (cnt_r == DEB_LAST);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cnt_r <= '0;
                    stable_r[gi] <= 1'b0;
                end else if (sensed[gi] == stable_r[gi]) begin
                    cnt_r <= '0;
                end else if (chg[gi]) begin
                    cnt_r <= '0;
                    stable_r[gi] <= sensed[gi];
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    endgenerate

    // Pedal value by wiring type; the converter is assumed to hold its word steady
    wire [6:0] ped_val = (j3_mode == `MODE3_PED_T) ? filt_r[16:10] : filt_r[9:3];
    logic [6:0] ped_last_r;

    // Pending events; a switch change wins over its clear; a pedal word taken now cannot re-arm
    seq_state_t st_r;
    logic [3:0] pend_r;
    logic [1:0] cur_j_r;
    logic cur_on_r;
    logic [6:0] cur_val_r;
    logic [PW-1:0] part_r;
    wire take = (st_r == ST_IDLE) && (pend_r != 4'h0);
    wire [1:0] pick = pend_r[0] ? 2'd0 : pend_r[1] ? 2'd1 : pend_r[2] ? 2'd2 : 2'd3;
    wire [3:0] pend_clr = take ? (4'h1 << pick) : 4'h0;
    wire [3:0] pend_set = {ped_en & (ped_val != ped_last_r) & ~pend_clr[3], chg & sw_en};

    // Sequencer: one message in program mode, one per enabled part in performance mode
    logic buf_ready;
    wire [1:0] en_j = (cur_j_r == 2'd3) ? 2'd2 : cur_j_r;
    wire en_hit = txen_r[3*part_r + en_j];
    wire sending = st_r == ST_SEND;
    wire push = sending && buf_ready && (~perf || en_hit);
    wire advance = sending && (perf ? (~en_hit || push) : push);
    wire last = ~perf || (part_r == PART_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_IDLE;
            pend_r <= 4'h0;
            cur_j_r <= 2'd0;
            cur_on_r <= 1'b0;
            cur_val_r <= 7'h00;
            part_r <= '0;
            ped_last_r <= 7'h00;
        end else begin
            pend_r <= (pend_r & ~pend_clr) | pend_set;
            unique case (st_r)
                ST_IDLE: begin
                    if (take) begin
                        st_r <= ST_SEND;
                        cur_j_r <= pick;
                        cur_on_r <= (pick == 2'd3) ? 1'b0 : stable_r[pick];
                        cur_val_r <= ped_val;
                        part_r <= '0;
                        if (pick == 2'd3) begin
                            ped_last_r <= ped_val;
                        end
                    end
                end
                ST_SEND: begin
                    if (advance) begin
                        if (last) begin
                            st_r <= ST_IDLE;
                        end else begin
                            part_r <= part_r + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Message content by jack
    wire m_nrpn = (cur_j_r == 2'd0) || (cur_j_r == 2'd2);
    wire [6:0] m_msb = (cur_j_r == 2'd0) ? `NRPN1_MSB : (cur_j_r == 2'd2) ? `NRPN3_MSB : 7'h00;
    wire [6:0] m_lsb = m_nrpn ? `NRPN_LSB :
                       (cur_j_r == 2'd1) ? `CC_SUSTAIN : `CC_BREATH;
    wire [6:0] m_val = (cur_j_r == 2'd3) ? cur_val_r :
                       cur_on_r ? `VAL_ON : `VAL_OFF;
    wire [3:0] m_ch = perf ? chan_r[4*part_r +: 4] : gchan;
    wire [MW-1:0] m_word = {m_nrpn, m_msb, m_lsb, m_val, m_ch};

    // Two-entry output buffer: an output stage and a skid stage; full stalls the sequencer
    logic [MW-1:0] out_r;
    logic out_v_r;
    logic [MW-1:0] skid_r;
    logic skid_v_r;
    wire out_take = ~out_v_r | msg_ready_i;
    assign buf_ready = ~skid_v_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_v_r <= 1'b0;
            skid_v_r <= 1'b0;
            out_r <= '0;
            skid_r <= '0;
        end else if (out_take) begin
            out_v_r <= skid_v_r | push;
            out_r <= skid_v_r ? skid_r : m_word;
            skid_v_r <= 1'b0;
        end else if (push) begin
            skid_r <= m_word;
            skid_v_r <= 1'b1;
        end
    end
    assign msg_valid_o = out_v_r;
    assign {msg_nrpn_o, msg_num_msb_o, msg_num_lsb_o, msg_value_o, msg_chan_o} = out_r;

    // Program mode functions follow the debounced switch levels
    logic arp_mute_r;
    logic sustain_r;
    logic arp_latch_r;
    logic freeze_r;
    logic audio1_r;
    logic audio2_r;
    wire pg = ~perf;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arp_mute_r <= 1'b0;
            sustain_r <= 1'b0;
            arp_latch_r <= 1'b0;
            freeze_r <= 1'b0;
            audio1_r <= 1'b1;
            audio2_r <= 1'b1;
        end else begin
            arp_mute_r <= pg & sw_en[0] & stable_r[0];
            sustain_r <= pg & sw_en[1] & stable_r[1] & ~arp_on;
            arp_latch_r <= pg & sw_en[1] & stable_r[1] & arp_on;
            freeze_r <= pg & sw_en[2] & stable_r[2];
            audio1_r <= ~sw_en[0];
            audio2_r <= ~sw_en[1];
        end
    end
    assign {arp_mute_o, sustain_o, arp_latch_o, voc_freeze_o} = {arp_mute_r, sustain_r,
                                                                 arp_latch_r, freeze_r};
    assign {audio1_avail_o, audio2_avail_o} = {audio1_r, audio2_r};

    // Part responses: a local event first, then a received one in the same cycle
    wire loc_ev = push & perf & (cur_j_r != 2'd3);
    wire rx_on = rx_value_i >= `VAL_HALF;
    generate
        for (gi = 0; gi < NPARTS; gi++) begin : g_part
            logic [2:0] pst_r;
            wire resp_t r_sus = rsus_r[3*gi +: 3];
            wire resp_t r_sw1 = rsw1_r[3*gi +: 3];
            wire resp_t r_sw3 = rsw3_r[3*gi +: 3];
            wire resp_t r_loc = (cur_j_r == 2'd0) ? r_sw1 : (cur_j_r == 2'd1) ? r_sus : r_sw3;
            wire resp_t r_rx = (rx_kind_i == 2'd0) ? r_sw1 : (rx_kind_i == 2'd1) ? r_sus : r_sw3;
            wire hit_l = loc_ev && (part_r == PW'(gi));
            wire hit_r = perf && rx_valid_i && (rx_kind_i != 2'd3) &&
                         (rx_chan_i == chan_r[4*gi +: 4]);
            wire [2:0] st_l = hit_l ? apply(pst_r, r_loc, cur_on_r) : pst_r;
            wire [2:0] st_x = hit_r ? apply(st_l, r_rx, rx_on) : st_l;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pst_r <= 3'h0;
                end else begin
                    pst_r <= st_x;
                end
            end
            assign {part_mute_o[gi], part_latch_o[gi], part_sustain_o[gi]} = pst_r;
        end
    endgenerate

    // Register read mux; unmapped offsets read zero and ignore writes
    wire [31:0] stat_w = {22'h00_0000, sending, audio2_r, audio1_r, freeze_r,
                          arp_latch_r, sustain_r, arp_mute_r, stable_r};
    wire [31:0] rd_mux = sel_ctrl ? {20'h0_0000, ctrl_r} :
                         sel_txen ? 32'(txen_r) :
                         sel_chan ? 32'(chan_r) :
                         sel_rsus ? 32'(rsus_r) :
                         sel_rsw1 ? 32'(rsw1_r) :
                         sel_rsw3 ? 32'(rsw3_r) :
                         sel_stat ? stat_w : 32'h0000_0000;

    // Wishbone slave: ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            ctrl_r <= `CTRL_RST;
            txen_r <= '0;
            chan_r <= '0;
            rsus_r <= '0;
            rsw1_r <= '0;
            rsw3_r <= '0;
        end else begin
            ack_r <= req;
            dat_r <= req ? rd_mux : 32'h0000_0000;
            if (wr && sel_ctrl) ctrl_r <= 12'(wmerge({20'h0_0000, ctrl_r}, wb_dat_i, wb_sel_i));
            if (wr && sel_txen) txen_r <= (3*NPARTS)'(wmerge(32'(txen_r), wb_dat_i, wb_sel_i));
            if (wr && sel_chan) chan_r <= (4*NPARTS)'(wmerge(32'(chan_r), wb_dat_i, wb_sel_i));
            if (wr && sel_rsus) rsus_r <= (3*NPARTS)'(wmerge(32'(rsus_r), wb_dat_i, wb_sel_i));
            if (wr && sel_rsw1) rsw1_r <= (3*NPARTS)'(wmerge(32'(rsw1_r), wb_dat_i, wb_sel_i));
            if (wr && sel_rsw3) rsw3_r <= (3*NPARTS)'(wmerge(32'(rsw3_r), wb_dat_i, wb_sel_i));
        end
    end
    assign {wb_ack_o, wb_dat_o} = {ack_r, dat_r};

    // Checks on message content, gating and program functions
    nrpn_one_a: assert property (push && cur_j_r == 2'd0 |-> m_nrpn && m_msb == 7'h23
        && m_lsb == 7'h7a) else $error("jack one message number wrong");
    cc_sus_a: assert property (push && cur_j_r == 2'd1 |-> !m_nrpn
        && m_lsb == 7'h40) else $error("jack two message not controller 64");
    nrpn_three_a: assert property (push && cur_j_r == 2'd2 |-> m_nrpn
        && m_msb == 7'h24 && m_lsb == 7'h7a) else $error("jack three number wrong");
    sw_value_a: assert property (push && cur_j_r != 2'd3 |-> m_val ==
        (cur_on_r ? 7'h7f : 7'h00)) else $error("switch value not 127 or 0");
    cc_breath_a: assert property (push && cur_j_r == 2'd3 |-> !m_nrpn
        && m_lsb == 7'h02) else $error("pedal message not controller 2");
    mode_gate_a: assert property (chg[0] && !sw_en[0] |=> !pend_r[0] ||
        $past(pend_r[0])) else $error("unconfigured jack raised an event");
    part_en_a: assert property (push && perf |-> en_hit
        && m_ch == chan_r[4*part_r +: 4]) else $error("send without part enable");
    sus_latch_a: assert property ($rose(stable_r[1]) && pg && sw_en[1]
        |=> (sustain_r != arp_on) && (arp_latch_r == arp_on))
        else $error("jack two function wrong for arpeggio state");
    mute_follow_a: assert property (pg && sw_en[0] && $stable(pg) && $stable(sw_en)
        |=> arp_mute_r == $past(stable_r[0])) else $error("mute not following switch");
    freeze_a: assert property ($fell(stable_r[2]) && pg && sw_en[2] |=> !freeze_r)
        else $error("freeze not released");
    audio_hide_a: assert property (sw_en[0] |=> !audio1_r)
        else $error("audio one offered while switch");
    one_msg_a: assert property (chg[0] && sw_en[0] |=> pend_r[0])
        else $error("debounced change lost");
    bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule // footswitch_midi_event_gen

/* File: src/fsw_consts.svh */
// Offsets, field positions, message numbers and timing for the switch event block
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_TXEN 8'h04
`define OFF_CHAN 8'h08
`define OFF_RSUS 8'h0c
`define OFF_RSW1 8'h10
`define OFF_RSW3 8'h14
`define OFF_STAT 8'h18
// Control fields
`define CTRL_J1_LSB 0
`define CTRL_J2_LSB 2
`define CTRL_J3_LSB 4
`define CTRL_PERF 6
`define CTRL_ARP 7
`define CTRL_CH_LSB 8
`define CTRL_RST 12'h000
// Jack mode codes, jacks one and two
`define MODE_AUDIO 2'h0
`define MODE_SW 2'h1
`define MODE_SWI 2'h2
// Jack mode codes, jack three
`define MODE3_PED_R 2'h0
`define MODE3_PED_T 2'h1
`define MODE3_SW 2'h2
`define MODE3_SWI 2'h3
// Response codes
`define RESP_SUS 3'h1
`define RESP_SUS_I 3'h2
`define RESP_LAT 3'h3
`define RESP_LAT_I 3'h4
`define RESP_MUTE 3'h5
`define RESP_MUTE_I 3'h6
// Message numbers
`define NRPN_LSB 7'h7a
`define NRPN1_MSB 7'h23
`define NRPN3_MSB 7'h24
`define CC_SUSTAIN 7'h40
`define CC_BREATH 7'h02
`define VAL_ON 7'h7f
`define VAL_OFF 7'h00
`define VAL_HALF 7'h40
// Timing
`define CLK_MHZ 40
`define DEBOUNCE_US 5000
`endif

/* File: src/fsw_pkg.sv */
// Types shared by the switch event block
package fsw_pkg;
    typedef enum logic {ST_IDLE, ST_SEND} seq_state_t;
    typedef logic [2:0] resp_t;
endpackage

/* File: tb/footswitch_midi_event_gen_tb_top.sv */
// Self-checking bench for the switch event block
`timescale 1ns/1ps
`include "fsw_consts.svh"
module footswitch_midi_event_gen_tb_top;
    import fsw_pkg::*;
    localparam int NP = 2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rxv = 1'b0, stall = 1'b0, slow = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, rxc = 4'h0, mch;
    logic [31:0] wdat = 32'h0000_0000, rdat, r;
    logic [2:0] jack = 3'h0;
    logic [6:0] ring = 7'h00, tip = 7'h00, rxval = 7'h00, mmsb, mlsb, mval;
    logic [1:0] rxk = 2'h3;
    logic mv, mr, mn, amute, sus, lat, frz, av1, av2;
    logic [NP-1:0] psus, plat, pmute;
    int fails = 0, checks_done = 0, cycles = 0;
    // Debounce shortened to keep each switch event near a dozen cycles
    footswitch_midi_event_gen #(.NPARTS(NP), .DEBOUNCE_CYC(4)) uut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .jack_i(jack),
        .pedal_ring_i(ring), .pedal_tip_i(tip), .rx_valid_i(rxv), .rx_kind_i(rxk),
        .rx_chan_i(rxc), .rx_value_i(rxval), .msg_valid_o(mv), .msg_ready_i(mr),
        .msg_nrpn_o(mn), .msg_num_msb_o(mmsb), .msg_num_lsb_o(mlsb), .msg_value_o(mval),
        .msg_chan_o(mch), .arp_mute_o(amute), .sustain_o(sus), .arp_latch_o(lat),
        .voc_freeze_o(frz), .audio1_avail_o(av1), .audio2_avail_o(av2),
        .part_sustain_o(psus), .part_latch_o(plat), .part_mute_o(pmute));
    msg_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
        .valid_i(mv), .nrpn_i(mn), .msb_i(mmsb), .lsb_i(mlsb), .value_i(mval),
        .chan_i(mch), .ready_o(mr));
    // Clock and hang guard; the ceiling leaves ample margin over the planned run
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Classic single cycle: request stands until ack is sampled, then one idle cycle
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic set_jack(input int b, input logic v);
        @(posedge clk_i);
        jack[b] <= v;
        hold(30);
    endtask
    // Empty queue yields a pattern no real message can carry
    task automatic get_msg(input logic [25:0] e);
        int n;
        n = 0;
        while (sink.q.size() == 0 && n < 200) begin
            hold(1);
            n++;
        end
        check({6'h00, (sink.q.size() != 0) ? sink.q.pop_front() : 26'h3ff_ffff}, {6'h00, e});
        hold(3);
    endtask
    task automatic rx(input logic [1:0] k, input logic [3:0] c, input logic [6:0] v);
        @(posedge clk_i);
        rxv <= 1'b1;
        rxk <= k;
        rxc <= c;
        rxval <= v;
        @(posedge clk_i);
        rxv <= 1'b0;
        hold(3);
    endtask
    task automatic t_reset;
        wb_cycle(1'b0, `OFF_STAT, 32'h0000_0000);
        check(r, 32'h0000_0180);
        wb_cycle(1'b0, 8'h1c, 32'h0000_0000);
        check(r, 32'h0000_0000);
        set_jack(0, 1'b1);
        set_jack(1, 1'b1);
        check(32'(sink.q.size()), 32'h0000_0000);
        set_jack(0, 1'b0);
        set_jack(1, 1'b0);
    endtask
    task automatic t_jack1;
        slow <= 1'b1;
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0301);
        hold(2);
        check({av2, av1}, 32'h0000_0002);
        set_jack(0, 1'b1);
        get_msg({1'b1, 7'h23, 7'h7a, 7'h7f, 4'h3});
        check(amute, 1'b1);
        set_jack(0, 1'b0);
        get_msg({1'b1, 7'h23, 7'h7a, 7'h00, 4'h3});
        check(amute, 1'b0);
        hold(20);
        check(32'(sink.q.size()), 32'h0000_0000);
        slow <= 1'b0;
    endtask
    // Inverted mode with the contact open reads as pressed at once
    task automatic t_jack2;
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0308);
        get_msg({1'b0, 7'h00, 7'h40, 7'h7f, 4'h3});
        check({lat, sus, av1}, 32'h0000_0003);
        set_jack(1, 1'b1);
        get_msg({1'b0, 7'h00, 7'h40, 7'h00, 4'h3});
        check(sus, 1'b0);
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0388);
        set_jack(1, 1'b0);
        get_msg({1'b0, 7'h00, 7'h40, 7'h7f, 4'h3});
        check({lat, sus}, 32'h0000_0002);
        set_jack(1, 1'b1);
        get_msg({1'b0, 7'h00, 7'h40, 7'h00, 4'h3});
        check(lat, 1'b0);
    endtask
    task automatic t_jack3;
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0300);
        jack[1] <= 1'b0;
        ring <= 7'h55;
        get_msg({1'b0, 7'h00, 7'h02, 7'h55, 4'h3});
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0310);
        get_msg({1'b0, 7'h00, 7'h02, 7'h00, 4'h3});
        tip <= 7'h55;
        get_msg({1'b0, 7'h00, 7'h02, 7'h55, 4'h3});
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0320);
        set_jack(2, 1'b1);
        get_msg({1'b1, 7'h24, 7'h7a, 7'h7f, 4'h3});
        check(frz, 1'b1);
        set_jack(2, 1'b0);
        get_msg({1'b1, 7'h24, 7'h7a, 7'h00, 4'h3});
        check(frz, 1'b0);
    endtask
    // Only part two transmits on jack two; it responds with latch
    task automatic t_perf;
        wb_cycle(1'b1, `OFF_CHAN, 32'h0000_0095);
        wb_cycle(1'b1, `OFF_RSUS, 32'h0000_0019);
        wb_cycle(1'b1, `OFF_TXEN, 32'h0000_0010);
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0044);
        set_jack(1, 1'b1);
        get_msg({1'b0, 7'h00, 7'h40, 7'h7f, 4'h9});
        check({sus, plat[1]}, 32'h0000_0001);
        hold(20);
        check(32'(sink.q.size()), 32'h0000_0000);
        wb_cycle(1'b1, `OFF_TXEN, 32'h0000_0000);
        set_jack(1, 1'b0);
        check(32'(sink.q.size()), 32'h0000_0000);
        wb_cycle(1'b1, `OFF_RSW1, 32'h0000_0005);
        wb_cycle(1'b1, `OFF_RSW3, 32'h0000_0001);
        rx(2'h0, 4'h5, 7'h7f);
        check(pmute[0], 1'b1);
        rx(2'h2, 4'h5, 7'h7f);
        check(psus[0], 1'b1);
        rx(2'h1, 4'h9, 7'h00);
        check(plat[1], 1'b0);
        wb_cycle(1'b1, `OFF_RSUS, 32'h0000_001a);
        rx(2'h1, 4'h5, 7'h7f);
        check(psus[0], 1'b0);
    endtask
    // Three events while the sink stalls; none may be lost or reordered
    task automatic t_buffer;
        wb_cycle(1'b1, `OFF_CTRL, 32'h0000_0325);
        stall <= 1'b1;
        set_jack(0, 1'b1);
        set_jack(2, 1'b1);
        set_jack(1, 1'b1);
        check(mv, 1'b1);
        stall <= 1'b0;
        get_msg({1'b1, 7'h23, 7'h7a, 7'h7f, 4'h3});
        get_msg({1'b1, 7'h24, 7'h7a, 7'h7f, 4'h3});
        get_msg({1'b0, 7'h00, 7'h40, 7'h7f, 4'h3});
    endtask
    initial begin
        hold(2);
        rst_i <= 1'b0;
        hold(3);
        t_reset();
        t_jack1();
        t_jack2();
        t_jack3();
        t_perf();
        t_buffer();
        wrap_up();
    end
endmodule // footswitch_midi_event_gen_tb_top

/* File: tb/msg_sink.sv */
// Message sink model standing in for the MIDI transmitter and the internal parts
`timescale 1ns/1ps
module msg_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire logic nrpn_i,
    input wire logic [6:0] msb_i,
    input wire logic [6:0] lsb_i,
    input wire logic [6:0] value_i,
    input wire logic [3:0] chan_i,
    output logic ready_o
);
    logic phase_r;
    logic [25:0] q[$];
    // Ready drops on a stall, or every other cycle when slow, to exercise the buffer
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            ready_o <= ~stall_i & (~slow_i | phase_r);
        end
    end
    // A word is taken only where valid and ready meet at an edge
    always @(posedge clk_i) begin
        if (!rst_i && valid_i === 1'b1 && ready_o === 1'b1) begin
            q.push_back({nrpn_i, msb_i, lsb_i, value_i, chan_i});
        end
    end
endmodule // msg_sink
